// >>> tmcw_timer.sv
`timescale 1ns/1ps
module tmcw_timer
    import tmcw_pkg::*;
#(
    parameter logic [7:0] PRESCALE = TMCW_PRESCALE_DEF
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             pin_out_o,
    output logic             pin_oe_n_o
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  count_value;
        logic [7:0]  compare_value;
        logic [7:0]  compare_buffer;
        logic [1:0]  waveform_mode_select;
        logic [1:0]  compare_output_action;
        logic        run;
        logic        pin_direction_bit;
        logic        port_value;
        logic        compare_output_state;
        logic        overflow_flag;
        logic        compare_match_flag;
        logic        match_pend;
        logic        block_match;
        logic [7:0]  div_cnt;
        logic        ack;
        logic [31:0] rdata;
        logic        pin_out;
        logic        pin_oe_n;
    } tmcw_state_t;

    tmcw_state_t s;
    tmcw_state_t next_s;

    // pin driver stays off through reset and until the direction bit is set
    localparam tmcw_state_t TMCW_STATE_RST = '{pin_oe_n: 1'b1, default: '0};

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // pwm modes use the double buffer and ignore the force strobe
    function automatic logic tmcw_is_pwm(input logic [1:0] m);
        tmcw_is_pwm = m[0];
    endfunction : tmcw_is_pwm

    // output state after a match with the given action
    function automatic logic tmcw_apply(input logic [1:0] act, input logic cur);
        case (act)
            TMCW_ACT_TOG: tmcw_apply = ~cur;
            TMCW_ACT_CLR: tmcw_apply = 1'b0;
            TMCW_ACT_SET: tmcw_apply = 1'b1;
            default:      tmcw_apply = cur;
        endcase
    endfunction : tmcw_apply

    logic       tick;
    logic       wr_sel;
    logic       rd_sel;
    logic       match;
    logic [7:0] top;

    always_comb
    begin
        tick   = s.run && (s.div_cnt == PRESCALE);
        wr_sel = avs_write_i && !s.ack;
        rd_sel = avs_read_i && !s.ack;
        // clear-on-match uses compare value as ceiling
        top    = (s.waveform_mode_select == TMCW_CTC) ? s.compare_value : TMCW_MAX;
        // a count write blocks matches for the next tick
        match  = (s.count_value == s.compare_value) && !s.block_match;
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb
    begin
        next_s       = s;
        next_s.ack   = 1'b0;
        next_s.rdata = 32'h0000_0000;

        // tick divider; one-cycle enable
        if (!s.run || tick)
            next_s.div_cnt = 8'h00;
        else
            next_s.div_cnt = s.div_cnt + 8'h01;

        if (tick)
        begin
            // flag follows the match by one tick
            next_s.compare_match_flag = s.compare_match_flag | s.match_pend;
            next_s.match_pend  = match;
            next_s.block_match = 1'b0;
            // counting depends on mode and match only
            if (s.waveform_mode_select == TMCW_CTC && match)
                next_s.count_value = TMCW_BOTTOM;
            else
                next_s.count_value = s.count_value + 8'h01;
            // every mode flags the step from 0xFF; a ceiling of 0xFF clears through it as well
            if (s.count_value == TMCW_MAX)
                next_s.overflow_flag = 1'b1;
            // output state; zero action holds
            if (s.waveform_mode_select == TMCW_FAST && s.compare_output_action[1])
            begin
                // match gives action bit 0, wrap its inverse; compare at 0xFF leaves only the wrap level
                if (match && s.count_value != TMCW_MAX)
                    next_s.compare_output_state = s.compare_output_action[0];
                else if (s.count_value == TMCW_MAX)
                    next_s.compare_output_state = ~s.compare_output_action[0];
            end
            else if (match)
                next_s.compare_output_state = tmcw_apply(s.compare_output_action,
                                                         s.compare_output_state);
            // buffered compare loads at top
            if (tmcw_is_pwm(s.waveform_mode_select) && s.count_value == TMCW_MAX)
                next_s.compare_value = s.compare_buffer;
        end

        // register writes win over counting; a flag clear loses to a same-cycle event
        if (wr_sel)
        begin
            next_s.ack = 1'b1;
            case (avs_address_i[3:2])
                TMCW_ADDR_CTRL:
                begin
                    if (avs_byteenable_i[0])
                    begin
                        next_s.waveform_mode_select  = avs_writedata_i[TMCW_CTRL_MODE_LSB +: 2];
                        next_s.compare_output_action = avs_writedata_i[TMCW_CTRL_ACT_LSB +: 2];
                        next_s.run                   = avs_writedata_i[TMCW_CTRL_RUN_BIT];
                        next_s.pin_direction_bit     = avs_writedata_i[TMCW_CTRL_DIR_BIT];
                        next_s.port_value            = avs_writedata_i[TMCW_CTRL_PORT_BIT];
                        // force: no flag, no counter change
                        if (avs_writedata_i[TMCW_CTRL_FORCE]
                            && !tmcw_is_pwm(avs_writedata_i[TMCW_CTRL_MODE_LSB +: 2]))
                            next_s.compare_output_state =
                                tmcw_apply(avs_writedata_i[TMCW_CTRL_ACT_LSB +: 2],
                                           s.compare_output_state);
                    end
                    if (avs_byteenable_i[1] && avs_writedata_i[TMCW_CTRL_PRESET])
                        next_s.compare_output_state = avs_writedata_i[TMCW_CTRL_PRE_VAL];
                end
                TMCW_ADDR_COUNT:
                    if (avs_byteenable_i[0])
                    begin
                        next_s.count_value = avs_writedata_i[7:0];
                        next_s.block_match = 1'b1;
                        next_s.match_pend  = 1'b0;
                    end
                TMCW_ADDR_CMP:
                    if (avs_byteenable_i[0])
                    begin
                        next_s.compare_buffer = avs_writedata_i[7:0];
                        if (!tmcw_is_pwm(s.waveform_mode_select))
                            next_s.compare_value = avs_writedata_i[7:0];
                    end
                TMCW_ADDR_STATUS:
                    if (avs_byteenable_i[0])
                    begin
                        // a new event in the same cycle wins over the clear
                        if (avs_writedata_i[TMCW_ST_OVF] && !(tick && s.count_value == TMCW_MAX))
                            next_s.overflow_flag = 1'b0;
                        if (avs_writedata_i[TMCW_ST_CMF] && !(tick && s.match_pend))
                            next_s.compare_match_flag = 1'b0;
                    end
                default: ;
            endcase
        end
        else if (rd_sel)
        begin
            next_s.ack = 1'b1;
            case (avs_address_i[3:2])
                TMCW_ADDR_CTRL:
                    next_s.rdata = {24'h000000, s.port_value, s.pin_direction_bit, 1'b0, s.run,
                                    s.compare_output_action, s.waveform_mode_select};
                TMCW_ADDR_COUNT:  next_s.rdata = {24'h000000, s.count_value};
                TMCW_ADDR_CMP:    next_s.rdata = {24'h000000, s.compare_buffer};
                TMCW_ADDR_STATUS:
                    next_s.rdata = {29'h00000000, s.compare_output_state,
                                    s.compare_match_flag, s.overflow_flag};
                default:          next_s.rdata = 32'h0000_0000;
            endcase
        end

        // pin: source by action field only, direction by direction bit
        next_s.pin_out  = (next_s.compare_output_action != TMCW_ACT_NONE)
                          ? next_s.compare_output_state : next_s.port_value;
        next_s.pin_oe_n = ~next_s.pin_direction_bit;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            s <= TMCW_STATE_RST;
        else
            s <= next_s;
    end

    // outputs straight from flops; answer in the cycle after the request
    always_comb
    begin
        avs_readdata_o    = s.rdata;
        avs_waitrequest_o = !s.ack;
        pin_out_o         = s.pin_out;
        pin_oe_n_o        = s.pin_oe_n;
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    // pin level and enable are registered from the same fields as s
    a_pin_source: assert property (@(posedge clk_i) disable iff (rst_i)
        s.compare_output_action != TMCW_ACT_NONE |-> pin_out_o == s.compare_output_state)
        else $error("pin does not follow compare state");
    a_pin_port: assert property (@(posedge clk_i) disable iff (rst_i)
        s.compare_output_action == TMCW_ACT_NONE |-> pin_out_o == s.port_value)
        else $error("pin does not show port value");
    a_pin_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        pin_oe_n_o == !s.pin_direction_bit)
        else $error("pin enable not from direction bit");
    // counting sequence for normal, ctc and fast modes
    a_ctc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && match && s.waveform_mode_select == TMCW_CTC && !wr_sel |=> s.count_value == TMCW_BOTTOM)
        else $error("ctc did not clear");
    a_norm_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.count_value == TMCW_MAX && s.waveform_mode_select == TMCW_NORMAL && !wr_sel
        |=> s.count_value == TMCW_BOTTOM && s.overflow_flag)
        else $error("normal wrap or overflow missing");
    a_norm_step: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.waveform_mode_select == TMCW_NORMAL && !wr_sel
        |=> s.count_value == $past(s.count_value) + 8'h01)
        else $error("normal count did not step");
    a_fast_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.waveform_mode_select == TMCW_FAST && s.count_value == TMCW_MAX && !wr_sel
        |=> s.count_value == TMCW_BOTTOM)
        else $error("fast mode did not wrap");
    // flags; a clear in the same cycle as the event loses
    a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        s.overflow_flag && !wr_sel |=> s.overflow_flag)
        else $error("overflow flag lost");
    a_fast_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.waveform_mode_select == TMCW_FAST && s.count_value == TMCW_MAX |=> s.overflow_flag)
        else $error("fast overflow missing");
    a_match_pend: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && match && !wr_sel |=> s.match_pend)
        else $error("match not held for next tick");
    a_match_next: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.match_pend |=> s.compare_match_flag)
        else $error("match flag late");
    a_block_match: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sel && avs_address_i[3:2] == TMCW_ADDR_COUNT && avs_byteenable_i[0] |=> !match)
        else $error("match not blocked");
    // output state actions
    a_zero_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        s.compare_output_action == TMCW_ACT_NONE && !wr_sel |=> $stable(s.compare_output_state))
        else $error("state moved with zero action");
    a_ctc_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.waveform_mode_select == TMCW_CTC && match
        && s.compare_output_action == TMCW_ACT_TOG && !wr_sel
        |=> s.compare_output_state != $past(s.compare_output_state))
        else $error("ctc state did not toggle");
    a_fast_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.waveform_mode_select == TMCW_FAST && s.compare_output_action == TMCW_ACT_CLR && match
        && s.count_value != TMCW_MAX && !wr_sel |=> !s.compare_output_state)
        else $error("fast mode did not clear on match");
    a_fast_set_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && s.waveform_mode_select == TMCW_FAST && s.compare_output_action == TMCW_ACT_CLR
        && s.count_value == TMCW_MAX && !wr_sel |=> s.compare_output_state)
        else $error("fast mode did not set at wrap");
    // force strobe moves only the state
    a_force_set: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sel && avs_address_i[3:2] == TMCW_ADDR_CTRL && avs_byteenable_i[0]
        && avs_writedata_i[TMCW_CTRL_FORCE] && !avs_writedata_i[TMCW_CTRL_PRESET]
        && avs_writedata_i[TMCW_CTRL_MODE_LSB +: 2] == TMCW_NORMAL
        && avs_writedata_i[TMCW_CTRL_ACT_LSB +: 2] == TMCW_ACT_SET |=> s.compare_output_state)
        else $error("force did not set state");
    a_force_noflag: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_sel && avs_address_i[3:2] == TMCW_ADDR_CTRL && avs_byteenable_i[0]
        && avs_writedata_i[TMCW_CTRL_FORCE] && !tick
        |=> $stable(s.compare_match_flag) && $stable(s.count_value))
        else $error("force touched flag or count");
    // compare value loading
    a_buf_load: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && tmcw_is_pwm(s.waveform_mode_select) && s.count_value == TMCW_MAX
        |=> s.compare_value == $past(s.compare_buffer))
        else $error("buffered compare not loaded at top");
    a_direct_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        tick && !tmcw_is_pwm(s.waveform_mode_select) && !wr_sel |=> $stable(s.compare_value))
        else $error("unbuffered compare moved without a write");
endmodule : tmcw_timer

// >>> tmcw_pkg.sv
package tmcw_pkg;
    // -----------------------------------------------------------------
    // register map (word addresses, byte address = 4 * word)
    // -----------------------------------------------------------------
    localparam logic [1:0] TMCW_ADDR_CTRL   = 2'h0;
    localparam logic [1:0] TMCW_ADDR_COUNT  = 2'h1;
    localparam logic [1:0] TMCW_ADDR_CMP    = 2'h2;
    localparam logic [1:0] TMCW_ADDR_STATUS = 2'h3;
    // control fields
    localparam int TMCW_CTRL_MODE_LSB = 0;
    localparam int TMCW_CTRL_ACT_LSB  = 2;
    localparam int TMCW_CTRL_RUN_BIT  = 4;
    localparam int TMCW_CTRL_FORCE    = 5;
    localparam int TMCW_CTRL_DIR_BIT  = 6;
    localparam int TMCW_CTRL_PORT_BIT = 7;
    localparam int TMCW_CTRL_PRESET   = 8;
    localparam int TMCW_CTRL_PRE_VAL  = 9;
    // status fields (write one to clear flags)
    localparam int TMCW_ST_OVF  = 0;
    localparam int TMCW_ST_CMF  = 1;
    localparam int TMCW_ST_STATE = 2;
    // values
    localparam logic [7:0] TMCW_MAX    = 8'hFF;
    localparam logic [7:0] TMCW_BOTTOM = 8'h00;
    localparam logic [1:0] TMCW_ACT_NONE = 2'h0;
    localparam logic [1:0] TMCW_ACT_TOG  = 2'h1;
    localparam logic [1:0] TMCW_ACT_CLR  = 2'h2;
    localparam logic [1:0] TMCW_ACT_SET  = 2'h3;
    localparam logic [7:0] TMCW_PRESCALE_DEF = 8'h00;

    typedef enum logic [1:0]
    {
        TMCW_NORMAL = 2'b00,
        TMCW_PHASE  = 2'b01,
        TMCW_CTC    = 2'b10,
        TMCW_FAST   = 2'b11
    } tmcw_mode_t;
endpackage : tmcw_pkg

// >>> test_timer8_compare_waveform_modes.sv
`timescale 1ns/1ps
module test_timer8_compare_waveform_modes;
    import tmcw_pkg::*;
    // ------------------------------------------------------------
    // signals and bench model state
    // ------------------------------------------------------------
    logic        clk_i;
    logic        rst_i;
    logic [3:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        pin_out_o;
    logic        pin_oe_n_o;
    logic [31:0] q;
    logic [7:0]  pv;
    logic        st;
    logic        pl;
    logic [1:0]  m_act;
    logic        m_dir;
    logic        m_port;
    int          err_count;
    int          checks_done;
    int          seed;
    int          tog;
    int          hi;
    int          ex;

    tmcw_timer dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o));

    // 100 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] cw(input logic [1:0] m, input logic [1:0] a, input logic r, input logic f,
                                       input logic d, input logic p);
        cw = {24'h000000, p, d, f, r, a, m};
    endfunction : cw

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // request held until waitrequest is sampled low at a rising edge; read data taken at that edge
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
        avs_address_i   <= {a, 2'b00};
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= ~w;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        // one idle edge so the next call never rewrites a strobe in this time step
        @(posedge clk_i);
    endtask : bus

    task automatic setc(input logic [1:0] m, input logic [1:0] a, input logic r, input logic f, input logic d,
                        input logic p);
        m_act  = a;
        m_dir  = d;
        m_port = p;
        bus(1'b1, TMCW_ADDR_CTRL, cw(m, a, r, f, d, p));
    endtask : setc

    // pin is registered, so let two edges land before looking
    task automatic pchk;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("pin_out", (m_act != 2'h0) ? st : m_port, pin_out_o);
        chk("pin_oe_n", {31'h0, ~m_dir}, pin_oe_n_o);
        @(posedge clk_i);
    endtask : pchk

    task automatic runm(input logic [1:0] m, input int n);
        setc(m, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (n) @(posedge clk_i);
        setc(m, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask : runm

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // watchdog well beyond the expected run of some eight thousand cycles
    initial
    begin
        #500000;
        err_count++;
        test_done;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
        avs_byteenable_i = 4'h3;
        {err_count, checks_done} = '0;
        seed = 18;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 4; a++)
        begin
            bus(1'b0, 2'(a), 32'h0);
            chk("reset_reg", 32'h0, q);
        end
        // count writes accepted with the timer stopped
        repeat (4)
        begin
            pv = 8'($random(seed));
            bus(1'b1, TMCW_ADDR_COUNT, {24'h0, pv});
            bus(1'b0, TMCW_ADDR_COUNT, 32'h0);
            chk("count", {24'h0, pv}, q);
        end
        st = 1'b0;
        pv = 8'($random(seed));
        setc(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, pv[0]);
        pchk;
        setc(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, ~pv[0]);
        pchk;
        bus(1'b1, TMCW_ADDR_CTRL, cw(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0) | 32'h300);
        st = 1'b1;
        setc(2'h0, TMCW_ACT_TOG, 1'b0, 1'b0, 1'b1, 1'b0);
        pchk;
        // force strobe in every mode except TMCW_PHASE, with every action
        bus(1'b1, TMCW_ADDR_COUNT, 32'h33);
        for (int m = 0; m < 4; m++)
            for (int a = 3; a >= 0; a--)
                if (m != 1)
                begin
                    setc(2'(m), 2'(a), 1'b0, 1'b1, 1'b1, 1'b0);
                    if (m != 3)
                        st = (a == 3) ? 1'b1 : (a == 2) ? 1'b0 : (a == 1) ? ~st : st;
                    pchk;
                end
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("status", {29'h0, st, 2'b00}, q);
        bus(1'b0, TMCW_ADDR_COUNT, 32'h0);
        chk("count", 32'h33, q);
        // count write equal to compare must hide the first match; normal mode so compare lands at once
        setc(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
        bus(1'b1, TMCW_ADDR_CMP, 32'h10);
        bus(1'b1, TMCW_ADDR_COUNT, 32'h10);
        runm(2'h0, 60);
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("status", {29'h0, st, 2'b00}, q);
        bus(1'b1, TMCW_ADDR_COUNT, 32'h0F);
        runm(2'h0, 60);
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("status", {29'h0, st, 2'b10}, q);
        bus(1'b1, TMCW_ADDR_COUNT, 32'hF0);
        runm(2'h0, 60);
        bus(1'b0, TMCW_ADDR_COUNT, 32'h0);
        chk("count_wrapped", 32'h1, 32'(q < 32'h40));
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("status", {29'h0, st, 2'b11}, q);
        bus(1'b1, TMCW_ADDR_STATUS, 32'h3);
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("status", {29'h0, st, 2'b00}, q);
        // clear on match: period of six ticks, toggle each match
        bus(1'b1, TMCW_ADDR_COUNT, 32'h0);
        bus(1'b1, TMCW_ADDR_CMP, 32'h5);
        setc(2'h2, TMCW_ACT_TOG, 1'b1, 1'b0, 1'b1, 1'b0);
        tog = 0;
        pl = pin_out_o;
        repeat (60)
        begin
            @(negedge clk_i);
            tog += (pin_out_o !== pl);
            pl = pin_out_o;
        end
        chk("toggles", 32'h1, 32'(tog >= 9 && tog <= 11));
        @(posedge clk_i);
        setc(2'h2, TMCW_ACT_TOG, 1'b0, 1'b0, 1'b1, 1'b0);
        bus(1'b0, TMCW_ADDR_COUNT, 32'h0);
        chk("count_ceiling", 32'h1, 32'(q <= 32'h5));
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("flags", 32'h2, {30'h0, q[1:0]});
        // fast pwm duty over two full periods
        for (int a = 1; a < 4; a++)
            for (int i = 0; i < 3; i++)
            begin
                pv = (i == 0) ? 8'h00 : (i == 1) ? 8'h40 : 8'hFF;
                bus(1'b1, TMCW_ADDR_CMP, {24'h0, pv});
                setc(2'h3, 2'(a), 1'b1, 1'b0, 1'b1, 1'b0);
                repeat (300) @(posedge clk_i);
                hi = 0;
                repeat (512)
                begin
                    @(negedge clk_i);
                    hi += int'(pin_out_o === 1'b1);
                end
                ex = (a == 1) ? 256 : (pv == 8'hFF) ? ((a == 2) ? 512 : 0) : 2 * (int'(pv) + 1);
                if (a == 3 && pv != 8'hFF)
                    ex = 512 - ex;
                chk("duty", 32'h1, 32'(hi >= ex - 1 && hi <= ex + 1));
                @(posedge clk_i);
                setc(2'h3, 2'(a), 1'b0, 1'b0, 1'b1, 1'b0);
            end
        bus(1'b0, TMCW_ADDR_STATUS, 32'h0);
        chk("overflow", 32'h1, {31'h0, q[0]});
        test_done;
    end
endmodule : test_timer8_compare_waveform_modes
